// file: dsc_defs.svh
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
`define DSC_KIND_DATA    2'h1
`define DSC_GRP_WR       2'h0
`define DSC_GRP_WR2      2'h1
`define DSC_GRP_RD1      2'h2
`define DSC_GRP_RD2      2'h3
`define DSC_BIT_GCLR     3
`define DSC_BIT_GRST     2
`define DSC_ADR_CLK_LO   5'h00
`define DSC_ADR_CLK_HI   5'h0f
`define DSC_ADR_DSP_LO   5'h10
`define DSC_ADR_DSP_HI   5'h13
`define DSC_ADR_LED      5'h14
`define DSC_GENERAL_PIN_ONE_BIT    7
`define DSC_GENERAL_PIN_ZERO_BIT    6
`define DSC_KEY_BYTES    3'h2
`define DSC_GPIN_BYTES   3'h1
`define DSC_RC_BYTES     3'h4
`define DSC_ONE_BYTE     3'h1
`endif

// file: dsc_pkg.sv
package dsc_pkg;
  typedef enum logic [2:0] {
    DSC_OP_NONE,
    DSC_OP_WMEM,
    DSC_OP_WLED,
    DSC_OP_WGPIO,
    DSC_OP_RKEY,
    DSC_OP_RGPIN,
    DSC_OP_RRC,
    DSC_OP_RGEN
  } dsc_op_t;
  typedef enum logic [2:0] {
    DSC_RSRC_NONE,
    DSC_RSRC_KEY,
    DSC_RSRC_GPIN,
    DSC_RSRC_RC,
    DSC_RSRC_IRQ,
    DSC_RSRC_CFG,
    DSC_RSRC_DSP,
    DSC_RSRC_CLK
  } dsc_rsrc_t;
endpackage

// file: dsc_decoder.sv
`timescale 1ns/1ps
`include "dsc_defs.svh"
// How it works
// - first byte after slave address is a command; unaddressed bytes are dropped.
// - top bits 01 mark a data setting command, low six bits decoded.
// - bits 5:4 pick group, bits 1:0 pick operation.
// - bit 3 pulses guard timer count clear.
// - bit 2 pulses guard timer force enable and restart.
// - write op 00 writes clock memory 0x00-0x0f from pointer 0x00.
// - write op 01 writes display memory 0x10-0x13 from 0x10.
// - write op 10 stores next byte at discrete led address 0x14.
// - write op 11 drives bits 7 and 6 onto output general pins.
// - second write op 11 enters standby; others reserved; data ignored.
// - read op 00 returns two key bytes.
// - read op 01 returns general pin levels in bits 7 and 6.
// - read op 10 returns four remote control bytes.
// - read op 11 returns interrupt status.
// - second read 01 config bytes, 10 display memory, 00 reserved.
// - reset gives normal mode, auto increment, display pointer 0x10.
// - auto increment continues from last pointer, incrementing per byte.
// - display pointer wraps from last location back to 0x10.
// - separate clock and display pointers; clock read uses clock pointer.
// - writes without fresh address continue at their own pointer.
module dsc_decoder (
  input  wire logic                i_clk_sys,
  input  wire logic                i_reset_n,
  input  wire logic                i_frame_start,
  input  wire logic                i_frame_stop,
  input  wire logic                i_rx_valid,
  input  wire logic [7:0]          i_rx_byte,
  input  wire logic                i_rd_req,
  input  wire logic                i_adr_valid,
  input  wire logic                i_adr_clock,
  input  wire logic [4:0]          i_adr_value,
  input  wire logic                i_fixed_addr,
  input  wire logic                i_gpin_one_out,
  input  wire logic                i_gpin_zero_out,
  input  wire logic                i_general_pin_one,
  input  wire logic                i_general_pin_zero,
  output logic                     o_gtimer_clear,
  output logic                     o_gtimer_restart,
  output logic                     o_mem_we,
  output logic [4:0]               o_mem_addr,
  output logic [7:0]               o_mem_wdata,
  output logic                     o_general_pin_one,
  output logic                     o_general_pin_zero,
  output logic                     o_host_standby_output,
  output dsc_pkg::dsc_rsrc_t       o_rd_src,
  output logic [2:0]               o_rd_index,
  output logic [4:0]               o_rd_addr,
  output logic                     o_rd_strobe,
  output logic [7:0]               o_rd_gpin
);
  import dsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic       rst_meta_ff;
  logic       rst_sync_ff;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire rst_n = rst_sync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // general pin input sync, three stages
  logic [2:0] g1_sync_ff;
  logic [2:0] g0_sync_ff;
  logic       g1_level_ff;
  logic       g0_level_ff;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      g1_sync_ff  <= 3'h0;
      g0_sync_ff  <= 3'h0;
      g1_level_ff <= 1'b0;
      g0_level_ff <= 1'b0;
    end else begin
      g1_sync_ff <= {g1_sync_ff[1:0], i_general_pin_one};
      g0_sync_ff <= {g0_sync_ff[1:0], i_general_pin_zero};
      if (g1_sync_ff[1] == g1_sync_ff[2]) begin
        g1_level_ff <= g1_sync_ff[2];
      end
      if (g0_sync_ff[1] == g0_sync_ff[2]) begin
        g0_level_ff <= g0_sync_ff[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command capture
  logic       addressed_ff;
  logic       want_cmd_ff;
  dsc_op_t    op_ff;
  logic       op_clk_ff;
  logic [2:0] rd_left_ff;
  wire        byte_ok  = i_rx_valid && addressed_ff;
  wire        is_cmd   = byte_ok && want_cmd_ff;
  wire        is_data  = byte_ok && !want_cmd_ff;
  wire        is_dsc   = is_cmd && (i_rx_byte[7:6] == `DSC_KIND_DATA);
  wire [1:0]  grp      = i_rx_byte[5:4];
  wire [1:0]  sub      = i_rx_byte[1:0];

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addressed_ff <= 1'b0;
      want_cmd_ff  <= 1'b0;
    end else if (i_frame_start) begin
      addressed_ff <= 1'b1;
      want_cmd_ff  <= 1'b1;
    end else if (i_frame_stop) begin
      addressed_ff <= 1'b0;
      want_cmd_ff  <= 1'b0;
    end else if (is_cmd) begin
      want_cmd_ff  <= 1'b0;
    end
  end

  dsc_op_t    nxt_op;
  dsc_rsrc_t  nxt_src;
  logic [2:0] nxt_left;
  logic       nxt_clk;
  always_comb begin
    nxt_op   = DSC_OP_NONE;
    nxt_src  = DSC_RSRC_NONE;
    nxt_left = 3'h0;
    nxt_clk  = 1'b0;
    unique case (grp)
      `DSC_GRP_WR: begin
        unique case (sub)
          2'h0: begin
            nxt_op  = DSC_OP_WMEM;
            nxt_clk = 1'b1;
          end
          2'h1: nxt_op = DSC_OP_WMEM;
          2'h2: nxt_op = DSC_OP_WLED;
          2'h3: nxt_op = DSC_OP_WGPIO;
        endcase
      end
      `DSC_GRP_WR2: nxt_op = DSC_OP_NONE;
      `DSC_GRP_RD1: begin
        unique case (sub)
          2'h0: begin
            nxt_op   = DSC_OP_RKEY;
            nxt_src  = DSC_RSRC_KEY;
            nxt_left = `DSC_KEY_BYTES;
          end
          2'h1: begin
            nxt_op   = DSC_OP_RGPIN;
            nxt_src  = DSC_RSRC_GPIN;
            nxt_left = `DSC_GPIN_BYTES;
          end
          2'h2: begin
            nxt_op   = DSC_OP_RRC;
            nxt_src  = DSC_RSRC_RC;
            nxt_left = `DSC_RC_BYTES;
          end
          2'h3: begin
            nxt_op   = DSC_OP_RGEN;
            nxt_src  = DSC_RSRC_IRQ;
            nxt_left = `DSC_ONE_BYTE;
          end
        endcase
      end
      `DSC_GRP_RD2: begin
        unique case (sub)
          2'h0: nxt_op = DSC_OP_NONE;
          2'h1: begin
            nxt_op  = DSC_OP_RGEN;
            nxt_src = DSC_RSRC_CFG;
          end
          2'h2: begin
            nxt_op  = DSC_OP_RGEN;
            nxt_src = DSC_RSRC_DSP;
          end
          2'h3: begin
            nxt_op  = DSC_OP_RGEN;
            nxt_src = DSC_RSRC_CLK;
            nxt_clk = 1'b1;
          end
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointers
  logic [4:0] clk_ptr_ff;
  logic [4:0] dsp_ptr_ff;
  logic [2:0] rd_cnt_ff;
  wire        wr_byte = is_data && (op_ff == DSC_OP_WMEM);
  wire        rd_byte = i_rd_req && addressed_ff && !want_cmd_ff && (op_ff == DSC_OP_RGEN);
  wire        step    = (wr_byte || rd_byte) && !i_fixed_addr;
  wire        ptr_clk = (o_rd_src == DSC_RSRC_CLK) || (op_ff == DSC_OP_WMEM && op_clk_ff);
  wire        dsp_mem = (o_rd_src == DSC_RSRC_DSP) || (op_ff == DSC_OP_WMEM && !op_clk_ff);

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dsp_ptr_ff <= `DSC_ADR_DSP_LO;
    end else if (i_adr_valid && !i_adr_clock) begin
      dsp_ptr_ff <= i_adr_value;
    end else if (step && dsp_mem) begin
      if (dsp_ptr_ff >= `DSC_ADR_DSP_HI) begin
        dsp_ptr_ff <= `DSC_ADR_DSP_LO;
      end else begin
        dsp_ptr_ff <= dsp_ptr_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_ptr_ff <= `DSC_ADR_CLK_LO;
    end else if (i_adr_valid && i_adr_clock) begin
      clk_ptr_ff <= i_adr_value;
    end else if (step && ptr_clk) begin
      if (clk_ptr_ff >= `DSC_ADR_CLK_HI) begin
        clk_ptr_ff <= `DSC_ADR_CLK_LO;
      end else begin
        clk_ptr_ff <= clk_ptr_ff + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation state and read sequencing
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_ff       <= DSC_OP_NONE;
      op_clk_ff   <= 1'b0;
      o_rd_src    <= DSC_RSRC_NONE;
      rd_left_ff  <= 3'h0;
      o_rd_index  <= 3'h0;
      rd_cnt_ff   <= 3'h0;
    end else if (i_frame_start || i_frame_stop) begin
      op_ff      <= DSC_OP_NONE;
      o_rd_src   <= DSC_RSRC_NONE;
      rd_left_ff <= 3'h0;
      o_rd_index <= 3'h0;
      rd_cnt_ff  <= 3'h0;
    end else if (is_cmd) begin
      op_ff      <= is_dsc ? nxt_op : DSC_OP_NONE;
      op_clk_ff  <= nxt_clk;
      o_rd_src   <= is_dsc ? nxt_src : DSC_RSRC_NONE;
      rd_left_ff <= is_dsc ? nxt_left : 3'h0;
      o_rd_index <= 3'h0;
      rd_cnt_ff  <= 3'h0;
    end else if (i_rd_req && rd_left_ff != 3'h0) begin
      rd_left_ff <= rd_left_ff - 3'h1;
      o_rd_index <= rd_cnt_ff;
      rd_cnt_ff  <= rd_cnt_ff + 3'h1;
      if (rd_left_ff == 3'h1) begin
        op_ff <= DSC_OP_NONE;
      end
    end else if (is_data && (op_ff == DSC_OP_WLED || op_ff == DSC_OP_WGPIO)) begin
      op_ff <= DSC_OP_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_gtimer_clear        <= 1'b0;
      o_gtimer_restart      <= 1'b0;
      o_mem_we              <= 1'b0;
      o_mem_addr            <= 5'h00;
      o_mem_wdata           <= 8'h00;
      o_general_pin_one     <= 1'b0;
      o_general_pin_zero    <= 1'b0;
      o_host_standby_output <= 1'b0;
      o_rd_addr             <= 5'h00;
      o_rd_strobe           <= 1'b0;
      o_rd_gpin             <= 8'h00;
    end else begin
      o_gtimer_clear   <= is_dsc && i_rx_byte[`DSC_BIT_GCLR];
      o_gtimer_restart <= is_dsc && i_rx_byte[`DSC_BIT_GRST];
      o_mem_we         <= 1'b0;
      o_rd_strobe      <= rd_byte || (i_rd_req && rd_left_ff != 3'h0);
      o_rd_addr        <= ptr_clk ? clk_ptr_ff : dsp_ptr_ff;
      o_rd_gpin        <= {g1_level_ff, g0_level_ff, 6'h00};
      if (is_dsc && grp == `DSC_GRP_WR2 && sub == 2'h3) begin
        o_host_standby_output <= 1'b1;
      end
      if (wr_byte) begin
        o_mem_we    <= 1'b1;
        o_mem_addr  <= op_clk_ff ? clk_ptr_ff : dsp_ptr_ff;
        o_mem_wdata <= i_rx_byte;
      end else if (is_data && op_ff == DSC_OP_WLED) begin
        o_mem_we    <= 1'b1;
        o_mem_addr  <= `DSC_ADR_LED;
        o_mem_wdata <= i_rx_byte;
      end else if (is_data && op_ff == DSC_OP_WGPIO) begin
        if (i_gpin_one_out) begin
          o_general_pin_one <= i_rx_byte[`DSC_GENERAL_PIN_ONE_BIT];
        end
        if (i_gpin_zero_out) begin
          o_general_pin_zero <= i_rx_byte[`DSC_GENERAL_PIN_ZERO_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  unaddr_ignore_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (i_rx_valid && !addressed_ff) |=> !o_mem_we)
    else $error("unaddressed byte caused a write");
  gclr_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (is_dsc && i_rx_byte[3]) |=> o_gtimer_clear)
    else $error("guard clear missing");
  grst_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (is_dsc && i_rx_byte[2]) |=> o_gtimer_restart)
    else $error("guard restart missing");
  led_write_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (is_data && op_ff == DSC_OP_WLED) |=> (o_mem_we && o_mem_addr == 5'h14))
    else $error("led byte not at 0x14");
  standby_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (is_cmd && i_rx_byte == 8'h53) |=> o_host_standby_output)
    else $error("standby not entered");
  dsp_wrap_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (step && dsp_mem && dsp_ptr_ff == 5'h13 && !i_adr_valid) |=> dsp_ptr_ff == 5'h10)
    else $error("display pointer did not wrap");
  dsp_range_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (wr_byte && !op_clk_ff && dsp_ptr_ff >= 5'h10 && dsp_ptr_ff <= 5'h13)
      |=> o_mem_addr inside {[5'h10:5'h13]})
    else $error("display write out of range");
  reserved_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (is_cmd && i_rx_byte == 8'h70) |=> ##1 (op_ff == DSC_OP_NONE && !o_mem_we))
    else $error("reserved code acted");
  rc_count_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (is_cmd && i_rx_byte == 8'h62) |=> rd_left_ff == 3'h4)
    else $error("remote read length wrong");
endmodule

// file: dsc_host_model.sv
`timescale 1ns/1ps
module dsc_host_model (
  input  wire logic       i_clk_sys,
  output logic            o_frame_start,
  output logic            o_frame_stop,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte,
  output logic            o_rd_req,
  output logic            o_adr_valid,
  output logic            o_adr_clock,
  output logic [4:0]      o_adr_value
);
  initial begin
    {o_frame_start, o_frame_stop, o_rx_valid, o_rd_req} = 4'h0;
    {o_adr_valid, o_adr_clock} = 2'h0;
    o_rx_byte   = 8'h00;
    o_adr_value = 5'h00;
  end
  // one link byte time, 160 ns
  task automatic gap();
    repeat (16) @(negedge i_clk_sys);
  endtask
  // close any open transfer, address the device, then the command
  task automatic start(input logic [7:0] cmd);
    stop();
    o_frame_start = 1'b1;
    @(negedge i_clk_sys);
    o_frame_start = 1'b0;
    send(cmd);
  endtask
  task automatic stop();
    o_frame_stop = 1'b1;
    @(negedge i_clk_sys);
    o_frame_stop = 1'b0;
    gap();
  endtask
  task automatic send(input logic [7:0] b);
    o_rx_byte  = b;
    o_rx_valid = 1'b1;
    @(negedge i_clk_sys);
    o_rx_valid = 1'b0;
    o_rx_byte  = ~b;
    gap();
  endtask
  task automatic rd();
    o_rd_req = 1'b1;
    @(negedge i_clk_sys);
    o_rd_req = 1'b0;
    gap();
  endtask
  // address setting ahead of clock access or each fixed-mode byte
  task automatic adr(input logic sel, input logic [4:0] v);
    o_adr_valid = 1'b1;
    o_adr_clock = sel;
    o_adr_value = v;
    @(negedge i_clk_sys);
    o_adr_valid = 1'b0;
    o_adr_clock = ~sel;
    o_adr_value = ~v;
    gap();
  endtask
endmodule

// file: data_setting_command_decoder_tb_top.sv
`timescale 1ns/1ps
module data_setting_command_decoder_tb_top;
  import dsc_pkg::*;
  logic        i_clk_sys, i_reset_n, i_fixed_addr, i_gpin_one_out, i_gpin_zero_out;
  logic        i_general_pin_one, i_general_pin_zero, i_frame_start, i_frame_stop;
  logic        i_rx_valid, i_rd_req, i_adr_valid, i_adr_clock;
  logic [7:0]  i_rx_byte, o_mem_wdata, o_rd_gpin, d;
  logic [4:0]  i_adr_value, o_mem_addr, o_rd_addr, cp, dp;
  logic        o_gtimer_clear, o_gtimer_restart, o_mem_we, o_general_pin_one;
  logic        o_general_pin_zero, o_host_standby_output, o_rd_strobe, e1, e0;
  logic [2:0]  o_rd_index;
  dsc_rsrc_t   o_rd_src;
  logic [31:0] q[$];
  logic [31:0] rs = 32'h0000_0029;
  int          error_cnt, num_checks, cyc;
  logic [7:0]  gc [5] = '{8'h4c, 8'h48, 8'h44, 8'h8c, 8'h0c};
  logic [7:0]  rc [8] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h71, 8'h72, 8'h73};
  int          rn [8] = '{2, 1, 4, 1, 1, 1, 1, 1};
  dsc_rsrc_t   rsrc [8] = '{DSC_RSRC_KEY, DSC_RSRC_GPIN, DSC_RSRC_RC, DSC_RSRC_IRQ,
                            DSC_RSRC_NONE, DSC_RSRC_CFG, DSC_RSRC_DSP, DSC_RSRC_CLK};
  logic [9:0]  gv [3] = '{{2'b11, 8'h80}, {2'b10, 8'hc0}, {2'b01, 8'h40}};
  logic [7:0]  rw [4] = '{8'h50, 8'h51, 8'h52, 8'h53};

  dsc_host_model host_u (.i_clk_sys, .o_frame_start(i_frame_start), .o_frame_stop(i_frame_stop),
    .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte), .o_rd_req(i_rd_req),
    .o_adr_valid(i_adr_valid), .o_adr_clock(i_adr_clock), .o_adr_value(i_adr_value));
  dsc_decoder dut_u (.i_clk_sys, .i_reset_n, .i_frame_start, .i_frame_stop, .i_rx_valid,
    .i_rx_byte, .i_rd_req, .i_adr_valid, .i_adr_clock, .i_adr_value, .i_fixed_addr,
    .i_gpin_one_out, .i_gpin_zero_out, .i_general_pin_one, .i_general_pin_zero,
    .o_gtimer_clear, .o_gtimer_restart, .o_mem_we, .o_mem_addr, .o_mem_wdata,
    .o_general_pin_one, .o_general_pin_zero, .o_host_standby_output, .o_rd_src,
    .o_rd_index, .o_rd_addr, .o_rd_strobe, .o_rd_gpin);
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  function automatic logic [31:0] pk(input logic [7:0] k, a, b, c);
    return {k, a, b, c};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic take(input logic [31:0] seen);
    if (q.size() == 0) chk(seen, 32'h0);
    else chk(seen, q.pop_front());
  endtask
  task automatic tend(input string n);
    $display("test %s finished", n);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] cmd, input int n, inout logic [4:0] p,
                    input logic [4:0] lo, input logic [4:0] hi);
    host_u.start(cmd);
    repeat (n) begin
      d = rnd();
      q.push_back(pk(8'h01, {3'h0, p}, d, 8'h00));
      host_u.send(d);
      if (!i_fixed_addr) p = (p == hi) ? lo : p + 5'h01;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      print_verdict();
    end
  end
  always @(negedge i_clk_sys) begin
    if (o_mem_we) take(pk(8'h01, {3'h0, o_mem_addr}, o_mem_wdata, 8'h00));
    if (o_rd_strobe) take(pk(8'h02, {5'h0, o_rd_src},
      (o_rd_src == DSC_RSRC_DSP || o_rd_src == DSC_RSRC_CLK) ? {3'h0, o_rd_addr}
                                                              : {5'h0, o_rd_index},
      (o_rd_src == DSC_RSRC_GPIN) ? o_rd_gpin : 8'h00));
    if (o_gtimer_clear | o_gtimer_restart)
      take(pk(8'h03, {6'h0, o_gtimer_clear, o_gtimer_restart}, 8'h00, 8'h00));
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_reset_n, i_fixed_addr, i_gpin_one_out, i_gpin_zero_out} = 4'h0;
    {i_general_pin_one, i_general_pin_zero} = 2'h0;
    {cp, dp, e1, e0} = {5'h00, 5'h10, 2'b00};
    repeat (2) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    chk({o_host_standby_output, o_general_pin_one, o_general_pin_zero, o_rd_src}, 32'h0);
    foreach (gc[i]) begin
      if (gc[i][7:6] == 2'h1) q.push_back(pk(8'h03, {6'h0, gc[i][3:2]}, 8'h00, 8'h00));
      host_u.start(gc[i]);
    end
    host_u.stop();
    host_u.send(8'h4c);
    tend("guard");
    wr(8'h40, 2, cp, 5'h00, 5'h0f);
    wr(8'h41, 5, dp, 5'h10, 5'h13);
    wr(8'h41, 1, dp, 5'h10, 5'h13);
    host_u.adr(1'b1, 5'h05);
    cp = 5'h05;
    wr(8'h40, 1, cp, 5'h00, 5'h0f);
    host_u.adr(1'b0, 5'h13);
    dp = 5'h13;
    wr(8'h40, 1, cp, 5'h00, 5'h0f);
    wr(8'h41, 1, dp, 5'h10, 5'h13);
    i_fixed_addr = 1'b1;
    host_u.adr(1'b0, 5'h12);
    dp = 5'h12;
    wr(8'h41, 1, dp, 5'h10, 5'h13);
    host_u.adr(1'b0, 5'h11);
    dp = 5'h11;
    wr(8'h41, 1, dp, 5'h10, 5'h13);
    host_u.adr(1'b0, 5'h10);
    dp = 5'h10;
    wr(8'h41, 1, dp, 5'h10, 5'h13);
    i_fixed_addr = 1'b0;
    wr(8'h41, 1, dp, 5'h10, 5'h13);
    tend("writes");
    d = rnd();
    {i_general_pin_one, i_general_pin_zero} = d[1:0];
    host_u.adr(1'b1, 5'h09);
    cp = 5'h09;
    host_u.adr(1'b0, 5'h12);
    dp = 5'h12;
    foreach (rc[i]) begin
      host_u.start(rc[i]);
      for (int j = 0; j < rn[i]; j++) begin
        if (rsrc[i] != DSC_RSRC_NONE) q.push_back(pk(8'h02, {5'h0, rsrc[i]},
          (rsrc[i] == DSC_RSRC_DSP) ? {3'h0, dp} : (rsrc[i] == DSC_RSRC_CLK) ? {3'h0, cp} : 8'(j),
          (rsrc[i] == DSC_RSRC_GPIN) ? {d[1:0], 6'h0} : 8'h00));
        host_u.rd();
      end
    end
    tend("reads");
    host_u.start(8'h42);
    d = rnd();
    q.push_back(pk(8'h01, 8'h14, d, 8'h00));
    host_u.send(d);
    host_u.send(rnd());
    foreach (gv[i]) begin
      {i_gpin_one_out, i_gpin_zero_out} = gv[i][9:8];
      host_u.start(8'h43);
      host_u.send(gv[i][7:0]);
      host_u.send(~gv[i][7:0]);
      if (gv[i][9]) e1 = gv[i][7];
      if (gv[i][8]) e0 = gv[i][6];
      chk({o_general_pin_one, o_general_pin_zero}, {e1, e0});
    end
    tend("led and pins");
    foreach (rw[i]) begin
      host_u.start(rw[i]);
      host_u.send(rnd());
      chk(o_host_standby_output, rw[i] == 8'h53);
    end
    tend("standby");
    chk(q.size(), 32'h0);
    print_verdict();
  end
endmodule
